// File: logic/dbus_data_phase.sv
`timescale 1ns/1ps
`include "dbus_regs.svh"
module dbus_data_phase #(
    parameter int DATA_W  = `DBUS_DATA_W,
    parameter int GROUP_W = `DBUS_GROUP_W
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // data lines
    input  wire logic [63:0]      data_n_seen,
    output logic      [63:0]      data_n_drive,
    output logic                  data_n_oe_n,
    // inversion flags
    input  wire logic [3:0]       group_invert_flags_n_seen,
    output logic      [3:0]       group_invert_flags_n_drive,
    output logic                  group_invert_flags_n_oe_n,
    // parity lines
    input  wire logic [3:0]       word_parity_lines_n_seen,
    output logic      [3:0]       word_parity_lines_n_drive,
    output logic                  word_parity_lines_n_oe_n,
    // strobes
    input  wire logic [3:0]       strobe_pos_phase_n_seen,
    output logic      [3:0]       strobe_pos_phase_n_drive,
    input  wire logic [3:0]       strobe_neg_phase_n_seen,
    output logic      [3:0]       strobe_neg_phase_n_drive,
    output logic                  strobe_n_oe_n,
    // handshakes
    input  wire logic             word_valid_flag_n_seen,
    output logic                  word_valid_flag_n_drive,
    input  wire logic             word_bus_occupied_n_seen,
    output logic                  word_bus_occupied_n_drive,
    output logic                  handshake_n_oe_n,
    input  wire logic             out_of_order_notice_n,
    // user send side, one block is four words of one bus clock
    input  wire logic             send_valid,
    output logic                  send_ready,
    input  wire dbus_pkg::block_t send_block,
    input  wire logic             send_last,
    // user receive side
    output logic                  recv_valid,
    output dbus_pkg::block_t      recv_block,
    output logic                  recv_parity_bad,
    output logic                  deferred
);
    import dbus_pkg::*;

    localparam int NG    = `DBUS_GROUPS;
    localparam int SLOTS = `DBUS_SLOTS;
    localparam int IN_W  = DATA_W + 4 * NG + 3;

    if (DATA_W != NG * GROUP_W || GROUP_W != 16 || SLOTS != 2 * `DBUS_WORDS)
    begin : bad_shape
        $error("dbus_data_phase: unsupported data shape");
    end

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers: every pin passes two flops before use

    logic [IN_W-1:0] sync1_reg;
    logic [IN_W-1:0] sync2_reg;
    logic [7:0]      strobe_s3_reg;
    wire  [IN_W-1:0] pins_raw = {data_n_seen, group_invert_flags_n_seen,
                                 word_parity_lines_n_seen, strobe_pos_phase_n_seen,
                                 strobe_neg_phase_n_seen, word_valid_flag_n_seen,
                                 word_bus_occupied_n_seen, out_of_order_notice_n};

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_reg     <= '1;
            sync2_reg     <= '1;
            strobe_s3_reg <= '1;
        end
        else
        begin
            sync1_reg     <= pins_raw;
            sync2_reg     <= sync1_reg;
            strobe_s3_reg <= sync2_reg[10:3];
        end
    end

    wire [63:0] data_s   = sync2_reg[IN_W-1 -: 64];
    wire [3:0]  flags_s  = sync2_reg[18:15];
    wire [3:0]  parity_s = sync2_reg[14:11];
    wire [3:0]  pos_s    = sync2_reg[10:7];
    wire [3:0]  neg_s    = sync2_reg[6:3];
    wire        valid_s  = sync2_reg[2];
    wire        busy_s   = sync2_reg[1];
    wire        out_of_order_notice_s  = sync2_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // send sequencing: one bus clock is SLOTS cycles, two per word

    phase_t         state_reg;
    phase_t         state_next;
    logic [2:0]     slot_reg;
    block_t         cur_block_reg;
    logic           cur_valid_reg;
    logic           cur_valid_next;
    logic           last_taken_reg;
    logic [63:0]    elec_next_all;
    logic [3:0]     flag_next_all;
    logic [3:0]     parity_next_all;

    // bus may be taken only after the current owner has released it
    wire bus_free   = busy_s && valid_s;
    wire period_end = slot_reg == 3'(SLOTS - 1);
    wire [1:0] word_idx = slot_reg[2:1];
    wire first_half = !slot_reg[0];
    wire sending    = state_reg == ST_DRIVE && cur_valid_reg;

    assign send_ready = (state_reg == ST_IDLE && bus_free)
                      || (state_reg == ST_DRIVE && period_end && !last_taken_reg);
    wire take = send_valid && send_ready;

    // no block offered at a bus clock boundary yields an idle clock
    always_comb
    begin
        state_next     = state_reg;
        cur_valid_next = cur_valid_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (take)
                begin
                    state_next     = ST_DRIVE;
                    cur_valid_next = 1'b1;
                end
            end
            ST_DRIVE:
            begin
                if (period_end)
                begin
                    cur_valid_next = take;
                    if (last_taken_reg)
                    begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE:
            begin
                state_next     = ST_IDLE;
                cur_valid_next = 1'b0;
            end
        endcase
    end

    // control state and the block being sent
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg      <= ST_IDLE;
            slot_reg       <= '0;
            cur_block_reg  <= '0;
            cur_valid_reg  <= 1'b0;
            last_taken_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            cur_valid_reg <= cur_valid_next;
            slot_reg      <= (state_reg == ST_DRIVE) ? slot_reg + 3'd1 : 3'd0;
            if (take)
            begin
                cur_block_reg  <= send_block;
                last_taken_reg <= send_last;
            end
            else if (state_reg != ST_DRIVE)
            begin
                last_taken_reg <= 1'b0;
            end
        end
    end

    // pin drive: a word loads in its first half, its strobe falls in the second
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_n_drive               <= '1;
            group_invert_flags_n_drive <= '1;
            word_parity_lines_n_drive  <= '1;
            strobe_pos_phase_n_drive   <= '1;
            strobe_neg_phase_n_drive   <= '1;
        end
        else if (!sending)
        begin
            strobe_pos_phase_n_drive <= '1;
            strobe_neg_phase_n_drive <= '1;
        end
        else if (first_half)
        begin
            data_n_drive               <= elec_next_all;
            group_invert_flags_n_drive <= flag_next_all;
            word_parity_lines_n_drive  <= parity_next_all;
            if (word_idx[0])
            begin
                strobe_neg_phase_n_drive <= '1;
            end
            else
            begin
                strobe_pos_phase_n_drive <= '1;
            end
        end
        else if (word_idx[0])
        begin
            strobe_neg_phase_n_drive <= '0;
        end
        else
        begin
            strobe_pos_phase_n_drive <= '0;
        end
    end

    // pins stay driven through the closing clock so the last strobe fall reaches the bus
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            word_valid_flag_n_drive   <= `DBUS_PIN_IDLE;
            word_bus_occupied_n_drive <= `DBUS_PIN_IDLE;
            handshake_n_oe_n          <= 1'b1;
            data_n_oe_n               <= 1'b1;
            group_invert_flags_n_oe_n <= 1'b1;
            word_parity_lines_n_oe_n  <= 1'b1;
            strobe_n_oe_n             <= 1'b1;
        end
        else
        begin
            word_valid_flag_n_drive   <= !(state_next == ST_DRIVE && cur_valid_next);
            word_bus_occupied_n_drive <= state_next == ST_IDLE;
            handshake_n_oe_n          <= state_reg == ST_IDLE && state_next == ST_IDLE;
            data_n_oe_n               <= state_next == ST_IDLE;
            group_invert_flags_n_oe_n <= state_next == ST_IDLE;
            word_parity_lines_n_oe_n  <= state_next == ST_IDLE;
            strobe_n_oe_n             <= state_next == ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // group lanes: encode, decode and parity per 16-bit group

    lane_if lanes[NG] ();
    logic [3:0] fall;
    logic [3:0] parity_bad_all;
    group_t     word_in_all [NG];

    for (genvar g = 0; g < NG; g++)
    begin : grp
        dbus_lane #(.GROUP_W(GROUP_W)) u_lane (.lane(lanes[g]));
        assign lanes[g].word_out      = cur_block_reg[word_idx * 64 + g * 16 +: 16];
        assign lanes[g].elec_prev     = data_n_drive[g * 16 +: 16];
        assign lanes[g].elec_seen     = data_s[g * 16 +: 16];
        assign lanes[g].flag_seen_n   = flags_s[g];
        assign lanes[g].parity_seen_n = parity_s[g];
        assign elec_next_all[g * 16 +: 16] = lanes[g].elec_next;
        assign flag_next_all[g]       = lanes[g].flag_next_n;
        assign parity_next_all[g]     = lanes[g].parity_next_n;
        assign word_in_all[g]         = lanes[g].word_in;
        assign parity_bad_all[g]      = lanes[g].parity_bad;
        // either strobe of the pair falling captures the next word of the group
        assign fall[g] = (strobe_s3_reg[4 + g] && !pos_s[g])
                       || (strobe_s3_reg[g] && !neg_s[g]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive: only while another agent owns the bus and marks data valid

    logic [1:0] rx_idx_reg [NG];
    logic [3:0] rx_done_reg;
    logic       rx_bad_reg;
    block_t     rx_block_reg;
    wire        rx_on = state_reg == ST_IDLE && !busy_s;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int g = 0; g < NG; g++)
            begin
                rx_idx_reg[g] <= '0;
            end
            rx_done_reg     <= '0;
            rx_bad_reg      <= 1'b0;
            rx_block_reg    <= '0;
            recv_valid      <= 1'b0;
            recv_block      <= '0;
            recv_parity_bad <= 1'b0;
            deferred        <= 1'b0;
        end
        else
        begin
            deferred   <= !out_of_order_notice_s;
            recv_valid <= 1'b0;
            if (&rx_done_reg)
            begin
                // the whole clock's four words have arrived in every group
                recv_valid      <= 1'b1;
                recv_block      <= rx_block_reg;
                recv_parity_bad <= rx_bad_reg;
                rx_done_reg     <= '0;
                rx_bad_reg      <= 1'b0;
            end
            else if (!rx_on)
            begin
                // a stray strobe outside an owned transfer must not skew words
                for (int g = 0; g < NG; g++)
                begin
                    rx_idx_reg[g] <= '0;
                end
                rx_done_reg <= '0;
                rx_bad_reg  <= 1'b0;
            end
            else
            begin
                for (int g = 0; g < NG; g++)
                begin
                    if (fall[g] && !valid_s)
                    begin
                        rx_block_reg[rx_idx_reg[g] * 64 + g * 16 +: 16] <= word_in_all[g];
                        rx_idx_reg[g] <= rx_idx_reg[g] + 2'd1;
                        if (parity_bad_all[g])
                        begin
                            rx_bad_reg <= 1'b1;
                        end
                        if (rx_idx_reg[g] == 2'd3)
                        begin
                            rx_done_reg[g] <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule

// File: include/dbus_regs.svh
`ifndef DBUS_REGS_SVH
`define DBUS_REGS_SVH
// data path shape
`define DBUS_DATA_W      64
`define DBUS_GROUPS      4
`define DBUS_GROUP_W     16
`define DBUS_WORDS       4
// timing: own clock period and the common bus clock period, in ns
`define DBUS_CLK_NS      40
`define DBUS_BUS_CLK_NS  320
// clk_sys cycles per common bus clock, two per word
`define DBUS_SLOTS       (`DBUS_BUS_CLK_NS / `DBUS_CLK_NS)
// idle level of every active low pin
`define DBUS_PIN_IDLE    1'b1
`endif

// File: include/dbus_pkg.sv
package dbus_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DRIVE = 2'b01,
        ST_DONE  = 2'b11
    } phase_t;
    typedef logic [255:0] block_t;
    typedef logic [15:0]  group_t;
endpackage

// File: include/lane_if.sv
`timescale 1ns/1ps
interface lane_if;
    import dbus_pkg::*;
    group_t word_out;      // logical word to send
    group_t elec_prev;     // pin levels now driven
    group_t elec_next;     // pin levels for the word
    logic   flag_next_n;
    logic   parity_next_n;
    group_t elec_seen;     // synchronised pin levels
    logic   flag_seen_n;
    logic   parity_seen_n;
    group_t word_in;       // decoded logical word
    logic   parity_bad;
    modport top  (output word_out, elec_prev, elec_seen, flag_seen_n, parity_seen_n,
                  input elec_next, flag_next_n, parity_next_n, word_in, parity_bad);
    modport lane (input word_out, elec_prev, elec_seen, flag_seen_n, parity_seen_n,
                  output elec_next, flag_next_n, parity_next_n, word_in, parity_bad);
endinterface

// File: logic/dbus_lane.sv
`timescale 1ns/1ps
module dbus_lane #(
    parameter int GROUP_W = 16
) (
    lane_if.lane lane
);
    import dbus_pkg::*;
    localparam int CW = $clog2(GROUP_W + 1);

    if (GROUP_W != 16)
    begin : bad_width
        $error("dbus_lane: group width must be 16");
    end

    logic [GROUP_W-1:0] plain_n;
    logic [GROUP_W-1:0] diff;
    logic [CW-1:0]      changes;
    logic               invert;

    // asserted data bit is a low pin level
    assign plain_n = ~lane.word_out;
    assign diff    = plain_n ^ lane.elec_prev;

    // count the lines that would toggle if sent plain
    always_comb
    begin
        changes = '0;
        for (int i = 0; i < GROUP_W; i++)
        begin
            changes = changes + {{(CW-1){1'b0}}, diff[i]};
        end
    end

    // more than half toggling: send inverted and flag it, halves switching noise
    assign invert             = changes > CW'(GROUP_W / 2);
    assign lane.elec_next     = invert ? lane.word_out : plain_n;
    assign lane.flag_next_n   = ~invert;
    // parity line asserted when the logical group holds an odd count of ones
    assign lane.parity_next_n = ~(^lane.word_out);

    // a flagged group reads active high, otherwise active low
    assign lane.word_in    = lane.flag_seen_n ? ~lane.elec_seen : lane.elec_seen;
    assign lane.parity_bad = (^lane.word_in) != ~lane.parity_seen_n;
endmodule

// File: bench/dbus_data_phase_assertions.sv
`timescale 1ns/1ps
module dbus_data_phase_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // pins driven
    input wire logic [63:0] data_n_drive,
    input wire logic        data_n_oe_n,
    input wire logic        group_invert_flags_n_oe_n,
    input wire logic [3:0]  word_parity_lines_n_drive,
    input wire logic        word_parity_lines_n_oe_n,
    input wire logic [3:0]  strobe_pos_phase_n_drive,
    input wire logic [3:0]  strobe_neg_phase_n_drive,
    input wire logic        strobe_n_oe_n,
    input wire logic        word_valid_flag_n_drive,
    input wire logic        word_bus_occupied_n_drive,
    input wire logic        handshake_n_oe_n,
    // user side and notice
    input wire logic        out_of_order_notice_n,
    input wire logic        send_valid,
    input wire logic        send_ready,
    input wire logic        recv_valid,
    input wire logic        deferred
);
    logic [63:0] prev_reg;
    logic [3:0]  par_exp;
    wire  [63:0] tog = data_n_drive ^ prev_reg;
    // pin levels one cycle back, so each load can be judged by its toggles
    always_ff @(posedge clk_sys)
        prev_reg <= data_n_drive;
    // inverting sixteen pins keeps the parity of the ones, so flags do not matter
    always_comb
        for (int g = 0; g < 4; g++)
            par_exp[g] = ~^data_n_drive[16*g +: 16];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    // hand back: busy up with handshakes still driven, then let go
    sequence release_s;
        !handshake_n_oe_n && word_bus_occupied_n_drive ##1 handshake_n_oe_n;
    endsequence
    sequence take_s;
        send_valid && send_ready && data_n_oe_n;
    endsequence
    own_busy_a: assert property (!data_n_oe_n |-> !word_bus_occupied_n_drive && !handshake_n_oe_n)
        else $error("data driven without bus busy");
    valid_own_a: assert property (!word_valid_flag_n_drive |-> !data_n_oe_n)
        else $error("data valid without driving data");
    take_own_a: assert property (take_s |=> !data_n_oe_n && !word_valid_flag_n_drive)
        else $error("take did not start driving");
    release_a: assert property ($rose(data_n_oe_n) |-> release_s)
        else $error("bus release order wrong");
    oe_group_a: assert property (data_n_oe_n == group_invert_flags_n_oe_n && data_n_oe_n == word_parity_lines_n_oe_n && data_n_oe_n == strobe_n_oe_n)
        else $error("pin groups enabled apart");
    strobe_same_a: assert property (strobe_pos_phase_n_drive inside {4'h0, 4'hf} && strobe_neg_phase_n_drive inside {4'h0, 4'hf})
        else $error("strobe pairs differ");
    alt_strobe_a: assert property ($fell(strobe_pos_phase_n_drive[0]) |-> ##2 $fell(strobe_neg_phase_n_drive[0]))
        else $error("strobes do not alternate");
    parity_pin_a: assert property (!data_n_oe_n && $changed(strobe_pos_phase_n_drive ^ strobe_neg_phase_n_drive) |-> word_parity_lines_n_drive == par_exp)
        else $error("parity pins wrong");
    invert_a: assert property (!data_n_oe_n |-> $countones(tog[15:0]) <= 8 && $countones(tog[31:16]) <= 8 && $countones(tog[47:32]) <= 8 && $countones(tog[63:48]) <= 8)
        else $error("group toggles more than half");
    out_of_order_notice_on_a: assert property (!out_of_order_notice_n [*4] |-> deferred)
        else $error("deferral not seen");
    out_of_order_notice_off_a: assert property (out_of_order_notice_n [*4] |-> !deferred)
        else $error("deferral stuck");
    recv_pulse_a: assert property (recv_valid |=> !recv_valid)
        else $error("receive pulse too long");
endmodule
bind dbus_data_phase dbus_data_phase_checker u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .data_n_drive(data_n_drive),
    .data_n_oe_n(data_n_oe_n), .group_invert_flags_n_oe_n(group_invert_flags_n_oe_n),
    .word_parity_lines_n_drive(word_parity_lines_n_drive),
    .word_parity_lines_n_oe_n(word_parity_lines_n_oe_n),
    .strobe_pos_phase_n_drive(strobe_pos_phase_n_drive),
    .strobe_neg_phase_n_drive(strobe_neg_phase_n_drive), .strobe_n_oe_n(strobe_n_oe_n),
    .word_valid_flag_n_drive(word_valid_flag_n_drive),
    .word_bus_occupied_n_drive(word_bus_occupied_n_drive), .handshake_n_oe_n(handshake_n_oe_n),
    .out_of_order_notice_n(out_of_order_notice_n), .send_valid(send_valid),
    .send_ready(send_ready), .recv_valid(recv_valid), .deferred(deferred));

// File: bench/dbus_far_agent.sv
`timescale 1ns/1ps
module dbus_far_agent (
    // device drive and enables
    input  wire logic [63:0] data_drive,
    input  wire logic        data_oe_n,
    input  wire logic [3:0]  flag_drive,
    input  wire logic [3:0]  par_drive,
    input  wire logic [3:0]  pos_drive,
    input  wire logic [3:0]  neg_drive,
    input  wire logic        strb_oe_n,
    input  wire logic        valid_drive,
    input  wire logic        busy_drive,
    input  wire logic        hs_oe_n,
    // resolved pin levels
    output wire logic [63:0] data_pin,
    output wire logic [3:0]  flag_pin,
    output wire logic [3:0]  par_pin,
    output wire logic [3:0]  pos_pin,
    output wire logic [3:0]  neg_pin,
    output wire logic        valid_pin,
    output wire logic        busy_pin
);
    logic [63:0] tx_data  = '1;
    logic [3:0]  tx_flag  = '1;
    logic [3:0]  tx_par   = '1;
    logic [3:0]  tx_pos   = '1;
    logic [3:0]  tx_neg   = '1;
    logic        tx_ctl_n = 1'b1;
    logic        tx_oe_n  = 1'b1;
    logic [63:0] rx_q [$];
    // terminated lines: a line nobody drives is pulled up to idle
    assign data_pin  = !data_oe_n ? data_drive : !tx_oe_n ? tx_data : '1;
    assign flag_pin  = !data_oe_n ? flag_drive : !tx_oe_n ? tx_flag : '1;
    assign par_pin   = !data_oe_n ? par_drive : !tx_oe_n ? tx_par : '1;
    assign pos_pin   = !strb_oe_n ? pos_drive : !tx_oe_n ? tx_pos : '1;
    assign neg_pin   = !strb_oe_n ? neg_drive : !tx_oe_n ? tx_neg : '1;
    assign valid_pin = !hs_oe_n ? valid_drive : tx_ctl_n;
    assign busy_pin  = !hs_oe_n ? busy_drive : tx_ctl_n;
    // capture a decoded word on each fall of either strobe while the device drives
    always @(negedge pos_pin[0] or negedge neg_pin[0])
        if (strb_oe_n === 1'b0)
            rx_q.push_back(data_pin ^ {{16{flag_pin[3]}}, {16{flag_pin[2]}}, {16{flag_pin[1]}}, {16{flag_pin[0]}}});
    // one block of four words; data held three cycles past each fall for the synchronisers
    task drive_block(input logic [255:0] blk, input logic bad_par);
        logic [15:0] lg;
        #13;
        tx_oe_n = 1'b0;
        tx_ctl_n = 1'b0;
        #120;
        for (int k = 0; k < 4; k++)
        begin
            for (int g = 0; g < 4; g++)
            begin
                lg = blk[64*k+16*g +: 16];
                tx_flag[g] = $countones(~lg ^ tx_data[16*g +: 16]) <= 8;
                tx_data[16*g +: 16] = tx_flag[g] ? ~lg : lg;
                tx_par[g] = ~^lg ^ (bad_par && k == 2 && g == 0);
            end
            #40;
            tx_pos = (k % 2 == 0) ? 4'h0 : 4'hf;
            tx_neg = (k % 2 == 0) ? 4'hf : 4'h0;
            #120;
        end
        #400;
        tx_oe_n = 1'b1;
        tx_ctl_n = 1'b1;
        tx_pos = 4'hf;
        tx_neg = 4'hf;
    endtask
endmodule

// File: bench/quad_pumped_data_bus_phase_test.sv
`timescale 1ns/1ps
module quad_pumped_data_bus_phase_test;
    import dbus_pkg::*;
    logic        clk_sys, reset_n, send_valid, send_last, out_of_order_notice_n;
    block_t      send_block, recv_block;
    wire  [63:0] d_drv, d_pin;
    wire  [3:0]  f_drv, f_pin, p_drv, p_pin, sp_drv, sp_pin, sn_drv, sn_pin;
    wire         d_oe, f_oe, p_oe, s_oe, v_drv, v_pin, b_drv, b_pin, h_oe;
    wire         send_ready, recv_valid, recv_parity_bad, deferred;
    int          miscompares = 0, samples_checked = 0;
    logic [31:0] seed = 32'h25;
    logic [63:0] exp_q [$];
    block_t      rexp_q [$];
    logic        pexp_q [$];
    dbus_data_phase u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .data_n_seen(d_pin),
        .data_n_drive(d_drv), .data_n_oe_n(d_oe), .group_invert_flags_n_seen(f_pin),
        .group_invert_flags_n_drive(f_drv), .group_invert_flags_n_oe_n(f_oe),
        .word_parity_lines_n_seen(p_pin), .word_parity_lines_n_drive(p_drv),
        .word_parity_lines_n_oe_n(p_oe), .strobe_pos_phase_n_seen(sp_pin),
        .strobe_pos_phase_n_drive(sp_drv), .strobe_neg_phase_n_seen(sn_pin),
        .strobe_neg_phase_n_drive(sn_drv), .strobe_n_oe_n(s_oe),
        .word_valid_flag_n_seen(v_pin), .word_valid_flag_n_drive(v_drv),
        .word_bus_occupied_n_seen(b_pin), .word_bus_occupied_n_drive(b_drv),
        .handshake_n_oe_n(h_oe), .out_of_order_notice_n(out_of_order_notice_n),
        .send_valid(send_valid), .send_ready(send_ready), .send_block(send_block),
        .send_last(send_last), .recv_valid(recv_valid), .recv_block(recv_block),
        .recv_parity_bad(recv_parity_bad), .deferred(deferred));
    dbus_far_agent u_far (.data_drive(d_drv), .data_oe_n(d_oe), .flag_drive(f_drv),
        .par_drive(p_drv), .pos_drive(sp_drv), .neg_drive(sn_drv), .strb_oe_n(s_oe),
        .valid_drive(v_drv), .busy_drive(b_drv), .hs_oe_n(h_oe), .data_pin(d_pin),
        .flag_pin(f_pin), .par_pin(p_pin), .pos_pin(sp_pin), .neg_pin(sn_pin),
        .valid_pin(v_pin), .busy_pin(b_pin));
    ////////////////////////////////////////////////////////////////////////////////
    task check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task check_bit(input string what, input logic exp, input logic got);
        check_word(what, 64'(exp), 64'(got));
    endtask
    task print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic block_t rand_blk();
        block_t b;
        for (int i = 0; i < 8; i++)
        begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            b[32*i +: 32] = seed;
        end
        return b;
    endfunction
    // offer a random block and leave valid up, so back to back offers never glitch
    task offer(input logic last);
        send_block = rand_blk();
        send_last = last;
        send_valid = 1'b1;
        for (int k = 0; k < 4; k++)
            exp_q.push_back(send_block[64*k +: 64]);
        @(negedge clk_sys);
        for (int n = 0; n < 200 && send_ready !== 1'b1; n++)
            @(negedge clk_sys);
        check_bit("ready", 1'b1, send_ready);
        @(posedge clk_sys);
        #1;
    endtask
    // wait for the bus hand back, then compare what the far side decoded
    task finish_tx();
        send_valid = 1'b0;
        for (int n = 0; n < 100 && d_oe !== 1'b1; n++)
            @(negedge clk_sys);
        check_bit("bus released", 1'b1, d_oe);
        repeat (4) @(negedge clk_sys);
        check_word("word count", 64'(exp_q.size()), 64'(u_far.rx_q.size()));
        while (exp_q.size() > 0 && u_far.rx_q.size() > 0)
            check_word("sent word", exp_q.pop_front(), u_far.rx_q.pop_front());
        exp_q.delete();
        u_far.rx_q.delete();
        @(posedge clk_sys);
        #1;
    endtask
    task far_tx(input logic bad);
        block_t b;
        b = rand_blk();
        rexp_q.push_back(b);
        pexp_q.push_back(bad);
        u_far.drive_block(b, bad);
    endtask
    // reference check of every receive pulse
    always @(negedge clk_sys)
        if (recv_valid === 1'b1)
        begin
            for (int k = 0; k < 4; k++)
                check_word("recv word", rexp_q[0][64*k +: 64], recv_block[64*k +: 64]);
            check_bit("recv parity", pexp_q.pop_front(), recv_parity_bad);
            void'(rexp_q.pop_front());
        end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        {reset_n, send_valid, send_last, send_block} = '0;
        out_of_order_notice_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        offer(1'b0);
        offer(1'b1);
        finish_tx();
        offer(1'b0);
        send_valid = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        check_bit("valid idle clock", 1'b1, v_drv);
        check_bit("still owning", 1'b0, d_oe);
        offer(1'b1);
        finish_tx();
        fork
            begin
                far_tx(1'b0);
                far_tx(1'b1);
            end
            begin
                repeat (6) @(negedge clk_sys);
                check_bit("ready while busy", 1'b0, send_ready);
            end
        join
        repeat (6) @(negedge clk_sys);
        check_word("recv left", 64'h0, 64'(rexp_q.size()));
        @(posedge clk_sys);
        #1;
        out_of_order_notice_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        check_bit("deferred on", 1'b1, deferred);
        @(posedge clk_sys);
        #1;
        out_of_order_notice_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        check_bit("deferred off", 1'b0, deferred);
        print_verdict();
    end
endmodule
